// ### rtl/duty_map_regs.vh
// register offsets, reset values and timing constants of the duty map
`ifndef DUTY_MAP_REGS_VH
`define DUTY_MAP_REGS_VH
`define ADDR_MIN_SPEED        4'h0
`define ADDR_MAX_SPEED        4'h1
`define ADDR_MIN_DUTY         4'h2
`define ADDR_MAX_DUTY         4'h3
`define ADDR_STOP_CTRL        4'h4
`define ADDR_DUTY_STATUS      4'h5
`define ADDR_SPEED_LO         4'h6
`define ADDR_SPEED_HI         4'h7
`define STOP_CODE_LSB         0
`define STOP_CODE_MSB         3
`define ABOVE_MAX_BIT         4
`define RST_MIN_SPEED         8'h00
`define RST_MAX_SPEED         8'hFF
`define RST_MIN_DUTY          8'h00
`define RST_MAX_DUTY          8'hFF
`define RST_STOP_CTRL         8'h00
`define STOP_CODE_USE_MIN     4'hF
`define STOP_STEP             4'h5
`define HYST_CODES            8'h04
`define MIN_PWM_FREQ_HZ       25
`define CLK_FREQ_HZ           100000000
`define PERIOD_TIMEOUT_CYC    ((`CLK_FREQ_HZ / `MIN_PWM_FREQ_HZ) * 2)
`endif

// ### rtl/speed_code_lut.v
// code to rpm lookup for the speed end points
`timescale 1ns/10ps
`default_nettype none
module speed_code_lut
(
	input  wire        clock,
	input  wire [7:0]  code,
	input  wire        max_table,
	output reg  [15:0] rpm
);

	// rpm of the maximum-speed table, piecewise by code segment
	function [15:0] max_rpm;
		input [7:0] c;
		begin
			if (c < 8'h20)
				max_rpm = 16'h012C + {7'h00, c, 1'b0} * 16'h000A;
			else if (c < 8'h40)
				max_rpm = 16'h03AC + {8'h00, c - 8'h20} * 16'h0014
					+ (c > 8'h29 ? {8'h00, c - 8'h29} * 16'h0014
					: 16'h0000);
			else if (c < 8'h4A)
				max_rpm = 16'h07F8 + {8'h00, c - 8'h40} * 16'h0028;
			else if (c < 8'h66)
				max_rpm = 16'h09C4 + {8'h00, c - 8'h4A} * 16'h0064;
			else if (c < 8'h80)
				max_rpm = 16'h1518 + {8'h00, c - 8'h66} * 16'h00C8;
			else
				max_rpm = 16'h2968 + {8'h00, c - 8'h80} * 16'h00C8;
		end
	endfunction

	// rpm of the minimum-speed table, code 0 means 0 rpm
	function [15:0] min_rpm;
		input [7:0] c;
		begin
			if (c == 8'h00)
				min_rpm = 16'h0000;
			else if (c < 8'h54)
				min_rpm = 16'h0122 + {8'h00, c} * 16'h000A;
			else if (c < 8'h94)
				min_rpm = 16'h0474 + {8'h00, c - 8'h54} * 16'h0014;
			else if (c < 8'hCB)
				min_rpm = 16'h0992 + {8'h00, c - 8'h94} * 16'h0032;
			else
				min_rpm = 16'h1450 + {8'h00, c - 8'hCB} * 16'h0064;
		end
	endfunction

	always @(posedge clock)
	begin
		rpm <= max_table ? max_rpm(code) : min_rpm(code);
	end
endmodule
`default_nettype wire

// ### rtl/duty_to_target_speed_map.v
// duty measurement and duty to target speed mapping
`timescale 1ns/10ps
`default_nettype none
`include "duty_map_regs.vh"
// Overview of operation
// - max-speed code maps monotonically, 300 rpm at 0x00 to 36000 at 0xFF.
// - duty codes mean code over 255 of full input duty.
// - speed interpolates linearly between minimum and maximum duty points.
// - above maximum duty hold max speed, or full output when selected.
// - stop codes 1 to 14 put the stop duty at five times code.
// - stop code 15 uses the minimum duty as the stop threshold.
// - between stop threshold and minimum duty hold minimum speed, else stop.
// - stop code 0 holds minimum speed below minimum duty, never stops.
// - a minimum duty below the stop threshold becomes the threshold.
// - after a stop restart only above threshold plus 1.6 percent.
// - minimum-speed code sets the low end point, not above maximum.
// - accept command frequencies from 12.5 Hz up to 100 kHz.
module duty_to_target_speed_map
#(
	parameter CNT_W       = 24,
	parameter TIMEOUT_CYC = `PERIOD_TIMEOUT_CYC
)
(
	input  wire        clock,
	input  wire        sys_rst,
	input  wire [3:0]  addr,
	input  wire [7:0]  wdata,
	input  wire        wr_en,
	input  wire        rd_en,
	output reg  [7:0]  rdata,
	input  wire        cmd_pwm,
	output reg  [15:0] target_rpm,
	output reg         full_drive,
	output reg         motor_stopped
);

	reg [7:0]        min_speed_q;
	reg [7:0]        max_speed_q;
	reg [7:0]        min_duty_q;
	reg [7:0]        max_duty_q;
	reg [7:0]        stop_ctrl_q;
	reg [2:0]        sync_q;
	reg [CNT_W-1:0]  per_cnt_q;
	reg [CNT_W-1:0]  hi_cnt_q;
	reg [7:0]        duty_q;
	reg [CNT_W+7:0]  num_q;
	reg [CNT_W-1:0]  den_q;
	reg [7:0]        quo_q;
	reg [3:0]        bit_q;
	reg              div_busy_q;
	reg              sel_q;
	reg [15:0]       min_rpm_q;
	reg [15:0]       max_rpm_q;
	reg              lvl_q;
	wire [15:0]      lut_rpm;

	//////////////////////////////////////////////////////////////////////
	// shared arithmetic
	// divisor aligned to the quotient bit under trial
	function [CNT_W+7:0] div_trial;
		input [CNT_W-1:0] d;
		input [3:0]       b;
		begin
			div_trial = {8'h00, d} << (b - 4'h1);
		end
	endfunction

	// distance of a duty code above the minimum duty point
	function [7:0] above_min;
		input [7:0] d;
		input [7:0] m;
		begin
			above_min = d - m;
		end
	endfunction

	//////////////////////////////////////////////////////////////////////
	// register port
	always @(posedge clock)
	begin
		if (sys_rst)
		begin
			min_speed_q <= `RST_MIN_SPEED;
			max_speed_q <= `RST_MAX_SPEED;
			min_duty_q  <= `RST_MIN_DUTY;
			max_duty_q  <= `RST_MAX_DUTY;
			stop_ctrl_q <= `RST_STOP_CTRL;
		end
		else if (wr_en)
		begin
			case (addr)
			`ADDR_MIN_SPEED: min_speed_q <= wdata;
			`ADDR_MAX_SPEED: max_speed_q <= wdata;
			`ADDR_MIN_DUTY:  min_duty_q  <= wdata;
			`ADDR_MAX_DUTY:  max_duty_q  <= wdata;
			`ADDR_STOP_CTRL: stop_ctrl_q <= {3'h0, wdata[4:0]};
			default:         min_speed_q <= min_speed_q;
			endcase
		end
	end

	always @(posedge clock)
	begin
		if (sys_rst)
			rdata <= 8'h00;
		else if (rd_en)
		begin
			case (addr)
			`ADDR_MIN_SPEED:   rdata <= min_speed_q;
			`ADDR_MAX_SPEED:   rdata <= max_speed_q;
			`ADDR_MIN_DUTY:    rdata <= min_duty_q;
			`ADDR_MAX_DUTY:    rdata <= max_duty_q;
			`ADDR_STOP_CTRL:   rdata <= stop_ctrl_q;
			`ADDR_DUTY_STATUS: rdata <= duty_q;
			`ADDR_SPEED_LO:    rdata <= target_rpm[7:0];
			`ADDR_SPEED_HI:    rdata <= target_rpm[15:8];
			default:           rdata <= 8'h00;
			endcase
		end
		else
			rdata <= 8'h00;
	end

	//////////////////////////////////////////////////////////////////////
	// command input sampling and period measurement
	// level moves only when the last two stages agree
	wire agree_hi = sync_q[2] & sync_q[1];
	wire agree_lo = ~(sync_q[2] | sync_q[1]);
	wire rise     = agree_hi & ~lvl_q;
	wire lvl      = lvl_q;

	always @(posedge clock)
	begin
		if (sys_rst)
		begin
			sync_q    <= 3'h0;
			lvl_q     <= 1'b0;
			per_cnt_q <= {CNT_W{1'b0}};
			hi_cnt_q  <= {CNT_W{1'b0}};
		end
		else
		begin
			sync_q <= {sync_q[1:0], cmd_pwm};
			if (agree_hi)
				lvl_q <= 1'b1;
			else if (agree_lo)
				lvl_q <= 1'b0;
			if (rise || per_cnt_q == TIMEOUT_CYC[CNT_W-1:0])
			begin
				per_cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1};
				hi_cnt_q  <= {CNT_W{1'b0}};
			end
			else
			begin
				per_cnt_q <= per_cnt_q + 1'b1;
				if (lvl)
					hi_cnt_q <= hi_cnt_q + 1'b1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// high times 255 over period
	always @(posedge clock)
	begin
		if (sys_rst)
		begin
			duty_q     <= 8'h00;
			num_q      <= {(CNT_W+8){1'b0}};
			den_q      <= {CNT_W{1'b0}};
			quo_q      <= 8'h00;
			bit_q      <= 4'h0;
			div_busy_q <= 1'b0;
		end
		else if (per_cnt_q == TIMEOUT_CYC[CNT_W-1:0])
		begin
			duty_q     <= lvl ? 8'hFF : 8'h00;
			div_busy_q <= 1'b0;
		end
		else if (rise && !div_busy_q)
		begin
			num_q      <= {hi_cnt_q, 8'h00} - {8'h00, hi_cnt_q};
			den_q      <= per_cnt_q;
			quo_q      <= 8'h00;
			bit_q      <= 4'h8;
			div_busy_q <= 1'b1;
		end
		else if (div_busy_q)
		begin
			if (bit_q == 4'h0)
			begin
				duty_q     <= quo_q;
				div_busy_q <= 1'b0;
			end
			else
			begin
				bit_q <= bit_q - 4'h1;
				if (num_q >= div_trial(den_q, bit_q))
				begin
					num_q <= num_q - div_trial(den_q, bit_q);
					quo_q <= quo_q | (8'h01 << (bit_q - 4'h1));
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// end point speeds through the shared lookup, alternating
	// min or max code lookup, picked by sel_q
	speed_code_lut u_lut
	(
		.clock     (clock),
		.code      (sel_q ? max_speed_q : min_speed_q),
		.max_table (sel_q),
		.rpm       (lut_rpm)
	);

	always @(posedge clock)
	begin
		if (sys_rst)
		begin
			sel_q     <= 1'b0;
			min_rpm_q <= 16'h0000;
			max_rpm_q <= 16'h0000;
		end
		else
		begin
			sel_q <= ~sel_q;
			if (sel_q)
				min_rpm_q <= lut_rpm;
			else
				max_rpm_q <= lut_rpm;
		end
	end

	wire [15:0] lo_rpm = (min_rpm_q > max_rpm_q) ? max_rpm_q : min_rpm_q;

	//////////////////////////////////////////////////////////////////////
	// stop threshold and interpolation
	wire [3:0] stop_code = stop_ctrl_q[`STOP_CODE_MSB:`STOP_CODE_LSB];
	wire       above_sel = stop_ctrl_q[`ABOVE_MAX_BIT];
	wire [7:0] stop_raw  = {4'h0, stop_code} * {4'h0, `STOP_STEP};
	wire       use_min   = (stop_code == `STOP_CODE_USE_MIN);
	wire       min_low   = (min_duty_q < stop_raw);
	wire [7:0] stop_thr  = (use_min || min_low) ? min_duty_q : stop_raw;
	wire [8:0] restart_thr = {1'b0, stop_thr} + {1'b0, `HYST_CODES};

	wire [7:0]  span_d  = above_min(max_duty_q, min_duty_q);
	wire [7:0]  pos_d   = above_min(duty_q, min_duty_q);
	wire [15:0] span_r  = max_rpm_q - lo_rpm;
	wire [23:0] prod    = span_r * pos_d;
	wire [23:0] step_r  = prod / {16'h0000, span_d};
	wire [15:0] interp  = (span_d == 8'h00) ? max_rpm_q :
		lo_rpm + step_r[15:0];

	always @(posedge clock)
	begin
		if (sys_rst)
		begin
			target_rpm    <= 16'h0000;
			full_drive    <= 1'b0;
			motor_stopped <= 1'b1;
		end
		else
		begin
			full_drive <= 1'b0;
			if (motor_stopped && stop_code != 4'h0 &&
				{1'b0, duty_q} <= restart_thr)
				target_rpm <= 16'h0000;
			else if (stop_code != 4'h0 && duty_q < stop_thr)
			begin
				target_rpm    <= 16'h0000;
				motor_stopped <= 1'b1;
			end
			else
			begin
				motor_stopped <= 1'b0;
				if (duty_q <= min_duty_q)
					target_rpm <= lo_rpm;
				else if (duty_q > max_duty_q)
				begin
					target_rpm <= max_rpm_q;
					full_drive <= above_sel;
				end
				else
					target_rpm <= interp;
			end
		end
	end
endmodule
`default_nettype wire

// ### verification/duty_map_properties.sv
// port assertions for the duty to speed map
`timescale 1ns/10ps
`default_nettype none
`include "duty_map_regs.vh"
module duty_map_properties
(
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire logic [3:0]  addr,
	input wire logic [7:0]  wdata,
	input wire logic        wr_en,
	input wire logic        rd_en,
	input wire logic [7:0]  rdata,
	input wire logic        cmd_pwm,
	input wire logic [15:0] target_rpm,
	input wire logic        full_drive,
	input wire logic        motor_stopped
);
	logic [4:0] ctrl_q;
	logic [2:0] quiet_q;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////
	// shadow of stop control, cycles since written
	always @(posedge clock)
	begin
		if (sys_rst)
		begin
			ctrl_q  <= 5'h00;
			quiet_q <= 3'h0;
		end
		else if (wr_en && addr == `ADDR_STOP_CTRL)
		begin
			ctrl_q  <= wdata[4:0];
			quiet_q <= 3'h0;
		end
		else if (quiet_q != 3'h7)
			quiet_q <= quiet_q + 3'h1;
	end
	sequence wr_at(a); wr_en && addr == a; endsequence
	sequence rd_at(a); rd_en && addr == a; endsequence
	property wr_rd(a);
		wr_at(a) ##1 rd_at(a) |=> rdata == $past(wdata, 2);
	endproperty
	////////////////////////////////////////
	AST_MIN_SPEED_RW: assert property (wr_rd(`ADDR_MIN_SPEED))
		else $error("min speed readback");
	AST_MAX_SPEED_RW: assert property (wr_rd(`ADDR_MAX_SPEED))
		else $error("max speed readback");
	AST_MIN_DUTY_RW: assert property (wr_rd(`ADDR_MIN_DUTY))
		else $error("min duty readback");
	AST_MAX_DUTY_RW: assert property (wr_rd(`ADDR_MAX_DUTY))
		else $error("max duty readback");
	AST_RDATA_IDLE: assert property (!rd_en |=> rdata == 8'h00)
		else $error("read data not idle");
	AST_STOP_ZERO: assert property (motor_stopped |-> target_rpm == 16'h0000)
		else $error("stopped with speed");
	AST_FULL_RUNS: assert property (full_drive |-> !motor_stopped)
		else $error("full drive while stopped");
	AST_RPM_CEIL: assert property (target_rpm <= 16'h8CA0)
		else $error("speed above ceiling");
	AST_NO_STOP: assert property (ctrl_q[3:0] == 4'h0 && quiet_q > 3'h3
		&& !motor_stopped |=> !motor_stopped)
		else $error("stop with code zero");
	AST_FULL_OFF: assert property (!ctrl_q[4] && quiet_q > 3'h3 |-> !full_drive)
		else $error("full drive not selected");
endmodule
bind duty_to_target_speed_map duty_map_properties u_duty_map_properties
	(.clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
	.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cmd_pwm(cmd_pwm),
	.target_rpm(target_rpm), .full_drive(full_drive),
	.motor_stopped(motor_stopped));
`default_nettype wire

// ### verification/pwm_host.sv
// host model driving the speed command input
`timescale 1ns/10ps
`default_nettype none
module pwm_host
#(
	parameter PERIOD = 1020
)
(
	input  wire logic        clock,
	input  wire logic [15:0] high,
	output var  logic        cmd_pwm
);
	logic [15:0] cnt_q = 16'h0000;
	// near 100 kHz, duty as told
	always @(posedge clock)
	begin
		cnt_q   <= (cnt_q == PERIOD - 1) ? 16'h0000 : cnt_q + 16'h0001;
		cmd_pwm <= cnt_q < high;
	end
endmodule
`default_nettype wire

// ### verification/test_duty_to_target_speed_map.sv
// self-checking bench for the duty to speed map
`timescale 1ns/10ps
`default_nettype none
`include "duty_map_regs.vh"
module test_duty_to_target_speed_map;
	logic        clock;
	logic        sys_rst;
	logic [3:0]  addr;
	logic [7:0]  wdata;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  rdata;
	logic        cmd_pwm;
	logic [15:0] target_rpm;
	logic        full_drive;
	logic        motor_stopped;
	logic [15:0] high;
	int          n_errors;
	int          n_checks;
	logic [7:0]  codes [4] = '{8'h00, 8'h40, 8'h80, 8'hFF};
	logic [15:0] rpms [4] = '{16'h012C, 16'h07F8, 16'h2968, 16'h8CA0};
	duty_to_target_speed_map #(.TIMEOUT_CYC(5000)) u_duty_to_target_speed_map
		(.clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cmd_pwm(cmd_pwm),
		.target_rpm(target_rpm), .full_drive(full_drive),
		.motor_stopped(motor_stopped));
	pwm_host u_pwm_host (.clock(clock), .high(high), .cmd_pwm(cmd_pwm));
	////////////////////////////////////////
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask
	task automatic rc(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock);
		rd_en <= 1'b1;
		addr  <= a;
		@(posedge clock);
		rd_en <= 1'b0;
		@(negedge clock);
		cmp({8'h00, rdata}, {8'h00, e});
	endtask
	// write, then read back in the very next cycle
	task automatic wrc(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		wr_en <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clock);
		wr_en <= 1'b0;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		@(negedge clock);
		cmp({8'h00, rdata}, {8'h00, d});
	endtask
	// four clocks per duty step, three periods plus settling
	task automatic dt(input logic [7:0] d);
		@(posedge clock);
		high <= {6'h00, d, 2'b00};
		wt(3200);
	endtask
	task automatic sc(input logic [15:0] e, input logic s);
		cmp(target_rpm, e);
		cmp({15'h0000, motor_stopped}, {15'h0000, s});
	endtask
	task automatic summarize;
		if (n_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial
	begin
		repeat (60000) @(posedge clock);
		n_errors++;
		summarize;
	end
	initial
	begin
		sys_rst = 1'b1;
		addr = 4'h0;
		wdata = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		high = 16'h0000;
		n_errors = 0;
		n_checks = 0;
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		rc(`ADDR_MIN_SPEED, `RST_MIN_SPEED);
		rc(`ADDR_MAX_SPEED, `RST_MAX_SPEED);
		rc(`ADDR_MIN_DUTY, `RST_MIN_DUTY);
		rc(`ADDR_MAX_DUTY, `RST_MAX_DUTY);
		rc(`ADDR_STOP_CTRL, `RST_STOP_CTRL);
		rc(4'hC, 8'h00);
		wrc(`ADDR_MIN_SPEED, 8'h15);
		wrc(`ADDR_MIN_DUTY, 8'h40);
		wrc(`ADDR_MAX_DUTY, 8'hC0);
		wrc(`ADDR_STOP_CTRL, 8'h04);
		dt(8'hE0);
		for (int i = 0; i < 4; i++)
		begin
			wrc(`ADDR_MAX_SPEED, codes[i]);
			wt(10);
			sc(rpms[i], 1'b0);
		end
		wrc(`ADDR_STOP_CTRL, 8'h14);
		wt(10);
		cmp({15'h0000, full_drive}, 16'h0001);
		wrc(`ADDR_STOP_CTRL, 8'h04);
		dt(8'h80);
		sc(16'h474A, 1'b0);
		rc(`ADDR_DUTY_STATUS, 8'h80);
		rc(`ADDR_SPEED_LO, 8'h4A);
		rc(`ADDR_SPEED_HI, 8'h47);
		dt(8'h40);
		sc(16'h01F4, 1'b0);
		dt(8'hC0);
		sc(16'h8CA0, 1'b0);
		dt(8'h20);
		sc(16'h01F4, 1'b0);
		dt(8'h10);
		sc(16'h0000, 1'b1);
		dt(8'h16);
		sc(16'h0000, 1'b1);
		dt(8'h1A);
		sc(16'h01F4, 1'b0);
		wrc(`ADDR_STOP_CTRL, 8'h0F);
		dt(8'h30);
		sc(16'h0000, 1'b1);
		wrc(`ADDR_STOP_CTRL, 8'h00);
		dt(8'h04);
		sc(16'h01F4, 1'b0);
		wrc(`ADDR_MIN_DUTY, 8'h10);
		wrc(`ADDR_STOP_CTRL, 8'h0E);
		dt(8'h0C);
		sc(16'h0000, 1'b1);
		dt(8'h20);
		cmp({15'h0000, motor_stopped}, 16'h0000);
		wrc(`ADDR_MAX_SPEED, 8'h00);
		wt(10);
		sc(16'h012C, 1'b0);
		summarize;
	end
endmodule
`default_nettype wire
